// ==== bench/mtc_host.sv ====
// Host loader model: one packet of len bytes, base plus index, per go pulse.
// Assumes valid and ready sampled at the rising edge.
module mtc_host (
    input wire logic clk_in, go_in, asis_in, ready_in,
    input wire logic [7:0] len_in, base_in,
    output logic valid_out = 1'h0, sop_out = 1'h0, eop_out = 1'h0, asis_out = 1'h0,
    output logic [7:0] data_out = 8'h00
);
    timeunit 1ns / 1ns;
    logic [7:0] i = 8'h00;
    always @(posedge clk_in) begin
        if (go_in) begin
            {valid_out, sop_out, asis_out, eop_out} <= {2'h3, asis_in, len_in == 8'h01};
            data_out <= base_in;
            i <= 8'h01;
        end else if (valid_out && ready_in) begin
            // Released data lines turn over
            data_out <= eop_out ? ~data_out : base_in + i;
            {valid_out, sop_out, eop_out} <= {!eop_out, 1'h0, i + 8'h01 == len_in};
            i <= i + 8'h01;
        end
    end
endmodule // mtc_host

// ==== bench/mtc_properties.sv ====
// Port checker of the transmit control block, bound to mtc_top below.
// Assumes settings are written only through the register port.
module mtc_chk (
    input wire logic clk_in, reset_n_in, reg_wr_in, reg_rd_in, irq_out, load_valid_in,
    input wire logic load_eop_in, load_ready_out, tx_en_out, tx_halted_out, flow_frame_req_out,
    input wire logic flow_frame_resume_out, pause_rx_active_in, phy_full_duplex_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in, reg_rdata_out
);
    timeunit 1ns / 1ns;
    logic [7:0] par, md, msk;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) {par, md, msk} <= 24'h0;
        else if (reg_wr_in && reg_addr_in == 3'h0) par <= reg_wdata_in;
        else if (reg_wr_in && reg_addr_in == 3'h1) md <= reg_wdata_in;
        else if (reg_wr_in && reg_addr_in == 3'h3) msk <= reg_wdata_in;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    halt_no_load_a: assert property (tx_halted_out |-> !load_ready_out)
        else $error("load open while halted");
    halt_no_tx_a: assert property (tx_halted_out && $past(tx_halted_out) |-> !tx_en_out)
        else $error("sending while halted");
    halt_cause_a: assert property ($rose(tx_halted_out) |-> md[2:0] != 3'h0)
        else $error("halt without stop setting");
    status_halt_a: assert property (
        $past(reg_rd_in && reg_addr_in == 3'h2 && tx_halted_out) |-> reg_rdata_out[7])
        else $error("halt not shown in status");
    irq_mask_a: assert property (irq_out |-> msk[2:0] != 3'h0)
        else $error("interrupt while masked");
    resume_quiet_a: assert property (flow_frame_req_out && flow_frame_resume_out |-> !par[3])
        else $error("resume frame while suppressed");
    one_packet_a: assert property (
        par[4] && load_valid_in && load_ready_out && load_eop_in |=> !load_ready_out)
        else $error("load open after last byte");
    pause_hold_a: assert property (
        (par[2] && phy_full_duplex_in && pause_rx_active_in) [*8] |-> !$rose(tx_en_out))
        else $error("frame started in pause");
endmodule // mtc_chk
bind mtc_top mtc_chk mtc_chk_inst (.*);

// ==== bench/mtc_top_tb.sv ====
// Bench of the transmit control block with host model and frame model.
// Assumes the checker binds itself.
module mtc_top_tb;
    timeunit 1ns / 1ns;
    logic clk_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, go = 0, asis = 0, ph = 0;
    logic phy_collision_in = 0, phy_full_duplex_in = 0, pause_rx_active_in = 0;
    logic flow_request_in = 0, irq_out, load_valid_in, load_sop_in, load_eop_in, load_asis_in;
    logic load_ready_out, tx_en_out, flow_frame_req_out, flow_frame_resume_out, tx_halted_out;
    logic [2:0] reg_addr_in = 0;
    logic [7:0] reg_wdata_in = 0, reg_rdata_out, tx_data_out, load_data_in, len = 0, base = 0;
    logic [7:0] rxq[$], e[$];
    int err_count = 0, checked = 0;
    mtc_top mtc_top_inst (.*);
    mtc_host mtc_host_inst (.clk_in, .go_in(go), .asis_in(asis), .ready_in(load_ready_out),
        .len_in(len), .base_in(base), .valid_out(load_valid_in), .sop_out(load_sop_in),
        .eop_out(load_eop_in), .asis_out(load_asis_in), .data_out(load_data_in));
    always #20 clk_in = !clk_in;
    // One byte per two-cycle slot
    always @(posedge clk_in) begin
        if (tx_en_out && !ph) rxq.push_back(tx_data_out);
        ph <= tx_en_out && !ph;
    end
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] x, g);
        checked++;
        if (g !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, v, 1'h1};
        @(posedge clk_in) reg_wr_in <= 0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] x);
        {reg_addr_in, reg_rd_in} <= {a, 1'h1};
        @(posedge clk_in) reg_rd_in <= 0;
        @(posedge clk_in) chk("rdata", x, reg_rdata_out);
    endtask
    task automatic wt(input int n, input bit busy);
        int k;
        for (k = 0; k < 5000 && !(rxq.size() >= n && (busy || tx_en_out === 0)); k++)
            @(posedge clk_in);
        if (k == 5000) begin
            err_count++;
            end_of_test();
        end
    endtask
    task automatic run(input logic [7:0] n, input logic a, c, input logic [7:0] p);
        logic [31:0] r = 32'hFFFFFFFF;
        wr(3'h0, p);
        {phy_full_duplex_in, pause_rx_active_in, flow_request_in} <= {3{p[2]}};
        repeat (12) @(posedge clk_in);
        {pause_rx_active_in, flow_request_in, base, len, asis, go} <= {2'h0, 8'($urandom), n, a, 1'h1};
        @(posedge clk_in) go <= 0;
        rxq = {};
        e = {};
        for (int i = 0; i < n; i++) e.push_back(base + i);
        while ((a || !p[1] && !p[0]) && e.size() < 60) e.push_back(8'h00);
        foreach (e[i]) for (int b = 0; b < 8; b++) r = (r[0] ^ e[i][b]) ? r >> 1 ^ 32'hEDB88320 : r >> 1;
        for (int b = 0; b < 4 && (a || !p[1]); b++) e.push_back(~r[8*b +: 8]);
        wt(c ? 70 : e.size(), c);
        if (c) begin
            phy_collision_in <= 1;
            wt(0, 0);
            @(posedge clk_in) phy_collision_in <= 0;
            chk("halted", 8'h01, 8'(tx_halted_out));
            chk("irq", 8'h01, 8'(irq_out));
            rd(3'h2, 8'h82);
            wr(3'h3, 8'h00);
            chk("irq", 8'h00, 8'(irq_out));
            wr(3'h2, 8'h82);
            chk("halted", 8'h00, 8'(tx_halted_out));
        end else begin
            chk("length", 8'(e.size()), 8'(rxq.size()));
            foreach (e[i]) chk("byte", e[i], rxq[i]);
        end
        $display("test len %0d asis %0d collide %0d params %h ends", n, a, c, p);
    endtask
    initial begin
        void'($urandom(94030));
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1;
        @(posedge clk_in);
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        wr(3'h1, 8'hFF);
        rd(3'h1, 8'h07);
        run(8'h0A, 0, 0, 8'h04);
        run(8'h0A, 0, 0, 8'h12);
        run(8'h0A, 1, 0, 8'h0F);
        run(8'h0E, 0, 0, 8'h01);
        wr(3'h1, 8'h02);
        wr(3'h3, 8'h02);
        run(8'h64, 0, 1, 8'h00);
        end_of_test();
    end
endmodule // mtc_top_tb

// ==== hw/mtc_cfg_if.sv ====
// Settings and error events between the register file and the transmit core.
// Assumes both ends run on the one system clock.
interface mtc_cfg_if;
    logic [7:0] params;
    logic [7:0] mode;
    logic [2:0] events;
    logic halted;
    logic restart;

    modport regs (output params, output mode, output restart, input events, input halted);
    modport core (input params, input mode, input restart, output events, output halted);
endinterface // mtc_cfg_if

// ==== hw/mtc_fifo_mem.sv ====
// Transmit FIFO storage, 256 words of data, end mark and unmodified flag.
// Assumes pointers are managed by the caller; read data come from a register.
module mtc_fifo_mem (
    // Clock
    input wire logic clk_in,
    // Write side
    input wire logic wr_en_in,
    input wire logic [7:0] wr_addr_in,
    input wire logic [9:0] wr_data_in,
    // Read side
    input wire logic [7:0] rd_addr_in,
    output logic [9:0] rd_data_out
);
    logic [9:0] store [0:255];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            store[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rd_data_out <= store[rd_addr_in];
    end
endmodule // mtc_fifo_mem

// ==== hw/mtc_map.svh ====
// Offsets, field positions, reset values and counts of the transmit control block.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef MTC_MAP_SVH
`define MTC_MAP_SVH

`define MTC_OFS_TRANSMIT_PARAMETERS 3'h0
`define MTC_OFS_ERROR_STOP_MODE 3'h1
`define MTC_OFS_ERROR_STATUS 3'h2
`define MTC_OFS_ERROR_MASK 3'h3

`define MTC_RST_TRANSMIT_PARAMETERS 8'h00
`define MTC_RST_ERROR_STOP_MODE 8'h00
`define MTC_RST_ERROR_STATUS 3'h0
`define MTC_RST_ERROR_MASK 3'h0

`define MTC_BIT_SINGLE_PACKET_LOAD 4
`define MTC_BIT_RESUME_FRAME_SUPPRESS 3
`define MTC_BIT_PAUSE_HONOUR_ENABLE 2
`define MTC_BIT_CRC_INSERT_DISABLE 1
`define MTC_BIT_PAD_DISABLE 0
`define MTC_PARAM_USED_MASK 8'h1F

`define MTC_BIT_EXCESS_COLLISION_STOP 2
`define MTC_BIT_LATE_COLLISION_STOP 1
`define MTC_BIT_UNDERFLOW_STOP 0
`define MTC_MODE_USED_MASK 8'h07

`define MTC_EV_UNDERFLOW 0
`define MTC_EV_LATE_COLLISION 1
`define MTC_EV_EXCESS_COLLISION 2
`define MTC_BIT_RESTART 7

`define MTC_FIFO_DEPTH 9'h100
`define MTC_BYTE_DIV_LAST 2'h1
`define MTC_MIN_DATA_BYTES 11'h03C
`define MTC_LATE_LIMIT 11'h040
`define MTC_LAST_ATTEMPT 4'hF
`define MTC_START_THRESH 9'h01C
`define MTC_GAP_SLOTS_LAST 4'hB
`define MTC_FCS_LAST 2'h3
`define MTC_CRC_INIT 32'hFFFFFFFF
`define MTC_CRC_POLY 32'hEDB88320

`endif

// ==== hw/mtc_pkg.sv ====
// Types and the frame check function of the transmit control block.
// Assumes nothing of its surroundings.
package mtc_pkg;
    typedef logic [8:0] mtc_ptr_t;

    typedef enum logic [2:0] {
        MTC_ST_IDLE = 3'h0,
        MTC_ST_SEND = 3'h1,
        MTC_ST_PAD = 3'h2,
        MTC_ST_FCS = 3'h3,
        MTC_ST_GAP = 3'h4,
        MTC_ST_DRAIN = 3'h5,
        MTC_ST_HALT = 3'h6
    } mtc_state_t;

    // One byte into the reflected Ethernet CRC
    function automatic logic [31:0] mtc_crc_byte(input logic [31:0] crc_now,
                                                 input logic [7:0] data);
        logic [31:0] r;
        r = crc_now;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ data[i]) ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// ==== hw/mtc_regs.sv ====
// Register file: settings, sticky error status, mask and interrupt.
// Assumes one-cycle strobes from a master on the same clock.
`include "mtc_map.svh"
module mtc_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    // Core side
    mtc_cfg_if.regs cfg_if
);
    import mtc_pkg::*;
    logic [2:0] status;
    logic [2:0] mask;
    logic wr_status;

    assign wr_status = wr_in && (addr_in == `MTC_OFS_ERROR_STATUS);
    assign cfg_if.restart = wr_status && wdata_in[`MTC_BIT_RESTART];

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cfg_if.params <= `MTC_RST_TRANSMIT_PARAMETERS;
            cfg_if.mode <= `MTC_RST_ERROR_STOP_MODE;
            mask <= `MTC_RST_ERROR_MASK;
        end else if (wr_in) begin
            case (addr_in)
                `MTC_OFS_TRANSMIT_PARAMETERS: cfg_if.params <= wdata_in & `MTC_PARAM_USED_MASK;
                `MTC_OFS_ERROR_STOP_MODE: cfg_if.mode <= wdata_in & `MTC_MODE_USED_MASK;
                `MTC_OFS_ERROR_MASK: mask <= wdata_in[2:0];
                default: ;
            endcase
        end
    end

    // Event set wins over a write-one clear
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            status <= `MTC_RST_ERROR_STATUS;
        end else begin
            status <= cfg_if.events | (status & ~(wr_status ? wdata_in[2:0] : 3'h0));
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `MTC_OFS_TRANSMIT_PARAMETERS: rdata_out <= cfg_if.params;
                `MTC_OFS_ERROR_STOP_MODE: rdata_out <= cfg_if.mode;
                `MTC_OFS_ERROR_STATUS: rdata_out <= {cfg_if.halted, 4'h0, status};
                `MTC_OFS_ERROR_MASK: rdata_out <= {5'h00, mask};
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    assign irq_out = |(status & mask);
endmodule // mtc_regs

// ==== hw/mtc_top.sv ====
// Per-port transmit control: packet FIFO loading, framing, error stop handling.
// Assumes a host loader on clk_in and PHY status pins from outside the clock domain.
//
// Overview of operation
// - With single packet load set, no new packet enters the FIFO until the last one left.
// - With resume frame suppress set, no resume frame is asked for when flow request drops.
// - With pause honour set in full duplex, no frame starts while pause frames come in.
// - With CRC insert disable set, a packet goes out as loaded, without pad or FCS.
// - A packet loaded with the unmodified flag at its start ignores both disable settings.
// - With pad disable and CRC insert disable clear, short packets are padded to 64 bytes including the FCS.
// - Pad disable is ignored while CRC insert disable is set.
// - A collision error whose stop bit is set, or an underflow after 64 bytes with its stop bit set, flushes the FIFO and halts transmission.
// - A stopping error is recorded in the transmit error status register.
// - An error raises the interrupt only when its mask bit is set.
// - With excessive collision stop set, the 16th collision of a packet stops transmission.
// - With excessive collision stop clear, a packet is retried after every collision before 64 bytes.
// - With late collision stop set, a collision after 64 bytes stops transmission.
// - With late collision stop clear, a late collided packet is dropped and the next sent.
// - With underflow stop set, an underflow after 64 bytes stops transmission.
// - With underflow stop clear, an underflowed packet is dropped and the next sent.
`include "mtc_map.svh"
module mtc_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic irq_out,
    // Host packet loading
    input wire logic load_valid_in,
    input wire logic [7:0] load_data_in,
    input wire logic load_sop_in,
    input wire logic load_eop_in,
    input wire logic load_asis_in,
    output logic load_ready_out,
    // PHY status pins
    input wire logic phy_collision_in,
    input wire logic phy_full_duplex_in,
    input wire logic pause_rx_active_in,
    input wire logic flow_request_in,
    // Transmit byte stream and flow frame requests
    output logic tx_en_out,
    output logic [7:0] tx_data_out,
    output logic flow_frame_req_out,
    output logic flow_frame_resume_out,
    output logic tx_halted_out
);
    import mtc_pkg::*;

    mtc_cfg_if cfg_bus();

    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic coll_hit;
    logic full_duplex;
    logic pause_rx;
    logic flow_req;
    logic flow_req_prev;
    logic [1:0] div_cnt;
    logic slot;
    mtc_state_t state;
    mtc_ptr_t wr_ptr;
    mtc_ptr_t rd_ptr;
    mtc_ptr_t commit_ptr;
    mtc_ptr_t wr_q1;
    mtc_ptr_t wr_q2;
    mtc_ptr_t used;
    logic eop_q1;
    logic eop_q2;
    logic [8:0] pkts;
    logic asis_hold;
    logic single_block;
    logic load_fire;
    logic full;
    logic avail;
    logic start_ok;
    logic pause_block;
    logic flush;
    logic [9:0] rd_data;
    logic [31:0] crc;
    logic [10:0] byte_cnt;
    logic [10:0] next_cnt;
    logic [3:0] attempts;
    logic [3:0] gap_cnt;
    logic [1:0] fcs_idx;
    logic eop_seen;
    logic eff_pad;
    logic eff_crc;
    logic late;
    logic [2:0] ev;
    logic retire_pulse;

    mtc_regs u_regs (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .addr_in(reg_addr_in),
        .wdata_in(reg_wdata_in),
        .wr_in(reg_wr_in),
        .rd_in(reg_rd_in),
        .rdata_out(reg_rdata_out),
        .irq_out(irq_out),
        .cfg_if(cfg_bus.regs)
    );

    mtc_fifo_mem u_mem (
        .clk_in(clk_in),
        .wr_en_in(load_fire),
        .wr_addr_in(wr_ptr[7:0]),
        .wr_data_in({load_sop_in ? load_asis_in : asis_hold, load_eop_in, load_data_in}),
        .rd_addr_in(rd_ptr[7:0]),
        .rd_data_out(rd_data)
    );

    // Pin synchronisers
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {flow_request_in, pause_rx_active_in, phy_full_duplex_in, phy_collision_in};
            pin_sync <= pin_meta;
        end
    end

    assign full_duplex = pin_sync[1];
    assign coll_hit = pin_sync[0] && !full_duplex;
    assign pause_rx = pin_sync[2];
    assign flow_req = pin_sync[3];

    // Byte slot divider
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= slot ? 2'h0 : 2'(div_cnt + 2'h1);
        end
    end

    assign slot = (div_cnt == `MTC_BYTE_DIV_LAST);

    // Flow frame requests on flow request edges
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            flow_req_prev <= 1'b0;
            flow_frame_req_out <= 1'b0;
            flow_frame_resume_out <= 1'b0;
        end else begin
            flow_req_prev <= flow_req;
            flow_frame_req_out <= 1'b0;
            if (flow_req && !flow_req_prev) begin
                flow_frame_req_out <= 1'b1;
                flow_frame_resume_out <= 1'b0;
            end else if (!flow_req && flow_req_prev &&
                         !cfg_bus.params[`MTC_BIT_RESUME_FRAME_SUPPRESS]) begin
                flow_frame_req_out <= 1'b1;
                flow_frame_resume_out <= 1'b1;
            end
        end
    end

    // Load side
    assign flush = (state == MTC_ST_HALT);
    assign full = (9'(wr_ptr - commit_ptr) == `MTC_FIFO_DEPTH);
    assign load_ready_out = !full && !flush && !single_block;
    assign load_fire = load_valid_in && load_ready_out;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wr_ptr <= 9'h000;
            asis_hold <= 1'b0;
        end else if (load_fire) begin
            wr_ptr <= 9'(wr_ptr + 9'h001);
            if (load_sop_in) begin
                asis_hold <= load_asis_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            single_block <= 1'b0;
        end else if (load_fire && load_eop_in && cfg_bus.params[`MTC_BIT_SINGLE_PACKET_LOAD]) begin
            single_block <= 1'b1;
        end else if (retire_pulse || flush) begin
            single_block <= 1'b0;
        end
    end

    // Write pointer delayed until memory read data can show it
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wr_q1 <= 9'h000;
            wr_q2 <= 9'h000;
            eop_q1 <= 1'b0;
            eop_q2 <= 1'b0;
        end else if (flush) begin
            wr_q1 <= wr_ptr;
            wr_q2 <= wr_ptr;
            eop_q1 <= 1'b0;
            eop_q2 <= 1'b0;
        end else begin
            wr_q1 <= wr_ptr;
            wr_q2 <= wr_q1;
            eop_q1 <= load_fire && load_eop_in;
            eop_q2 <= eop_q1;
        end
    end

    // Complete packets waiting in the FIFO
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || flush) begin
            pkts <= 9'h000;
        end else begin
            case ({eop_q2, retire_pulse})
                2'b10: pkts <= 9'(pkts + 9'h001);
                2'b01: pkts <= 9'(pkts - 9'h001);
                default: pkts <= pkts;
            endcase
        end
    end

    assign used = 9'(wr_q2 - rd_ptr);
    assign avail = (used != 9'h000);
    assign start_ok = (pkts != 9'h000) || (used >= `MTC_START_THRESH);
    assign pause_block = cfg_bus.params[`MTC_BIT_PAUSE_HONOUR_ENABLE] && full_duplex &&
                         pause_rx;
    assign late = (byte_cnt >= `MTC_LATE_LIMIT);
    assign next_cnt = 11'(byte_cnt + 11'h001);
    assign cfg_bus.events = ev;
    assign cfg_bus.halted = flush;
    assign tx_halted_out = flush;

    // Transmit sequencer
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state <= MTC_ST_IDLE;
            rd_ptr <= 9'h000;
            commit_ptr <= 9'h000;
            crc <= `MTC_CRC_INIT;
            byte_cnt <= 11'h000;
            attempts <= 4'h0;
            gap_cnt <= 4'h0;
            fcs_idx <= 2'h0;
            eop_seen <= 1'b0;
            eff_pad <= 1'b0;
            eff_crc <= 1'b0;
            tx_en_out <= 1'b0;
            tx_data_out <= 8'h00;
            ev <= 3'h0;
            retire_pulse <= 1'b0;
        end else begin
            ev <= 3'h0;
            retire_pulse <= 1'b0;
            if (slot && coll_hit &&
                (state == MTC_ST_SEND || state == MTC_ST_PAD || state == MTC_ST_FCS)) begin
                tx_en_out <= 1'b0;
                gap_cnt <= 4'h0;
                if (late) begin
                    ev[`MTC_EV_LATE_COLLISION] <= 1'b1;
                    if (cfg_bus.mode[`MTC_BIT_LATE_COLLISION_STOP]) begin
                        state <= MTC_ST_HALT;
                    end else if (eop_seen) begin
                        commit_ptr <= rd_ptr;
                        retire_pulse <= 1'b1;
                        attempts <= 4'h0;
                        state <= MTC_ST_GAP;
                    end else begin
                        state <= MTC_ST_DRAIN;
                    end
                end else if (attempts == `MTC_LAST_ATTEMPT &&
                             cfg_bus.mode[`MTC_BIT_EXCESS_COLLISION_STOP]) begin
                    ev[`MTC_EV_EXCESS_COLLISION] <= 1'b1;
                    state <= MTC_ST_HALT;
                end else begin
                    // Retry from the packet start; count saturates
                    if (attempts != `MTC_LAST_ATTEMPT) begin
                        attempts <= 4'(attempts + 4'h1);
                    end
                    rd_ptr <= commit_ptr;
                    state <= MTC_ST_GAP;
                end
            end else begin
                case (state)
                    MTC_ST_IDLE: begin
                        if (slot) begin
                            tx_en_out <= 1'b0;
                            if (start_ok && !pause_block) begin
                                eff_crc <= rd_data[9] ||
                                           !cfg_bus.params[`MTC_BIT_CRC_INSERT_DISABLE];
                                eff_pad <= rd_data[9] ||
                                           (!cfg_bus.params[`MTC_BIT_CRC_INSERT_DISABLE] &&
                                            !cfg_bus.params[`MTC_BIT_PAD_DISABLE]);
                                crc <= `MTC_CRC_INIT;
                                byte_cnt <= 11'h000;
                                fcs_idx <= 2'h0;
                                eop_seen <= 1'b0;
                                state <= MTC_ST_SEND;
                            end
                        end
                    end
                    MTC_ST_SEND: begin
                        if (slot) begin
                            if (!avail) begin
                                tx_en_out <= 1'b0;
                                ev[`MTC_EV_UNDERFLOW] <= 1'b1;
                                if (late && cfg_bus.mode[`MTC_BIT_UNDERFLOW_STOP]) begin
                                    state <= MTC_ST_HALT;
                                end else begin
                                    state <= MTC_ST_DRAIN;
                                end
                            end else begin
                                tx_en_out <= 1'b1;
                                tx_data_out <= rd_data[7:0];
                                crc <= mtc_crc_byte(crc, rd_data[7:0]);
                                byte_cnt <= next_cnt;
                                rd_ptr <= 9'(rd_ptr + 9'h001);
                                if (rd_data[8]) begin
                                    eop_seen <= 1'b1;
                                    if (eff_pad && next_cnt < `MTC_MIN_DATA_BYTES) begin
                                        state <= MTC_ST_PAD;
                                    end else if (eff_crc) begin
                                        state <= MTC_ST_FCS;
                                    end else begin
                                        commit_ptr <= 9'(rd_ptr + 9'h001);
                                        retire_pulse <= 1'b1;
                                        attempts <= 4'h0;
                                        gap_cnt <= 4'h0;
                                        state <= MTC_ST_GAP;
                                    end
                                end
                            end
                        end
                    end
                    MTC_ST_PAD: begin
                        if (slot) begin
                            tx_en_out <= 1'b1;
                            tx_data_out <= 8'h00;
                            crc <= mtc_crc_byte(crc, 8'h00);
                            byte_cnt <= next_cnt;
                            if (next_cnt >= `MTC_MIN_DATA_BYTES) begin
                                state <= MTC_ST_FCS;
                            end
                        end
                    end
                    MTC_ST_FCS: begin
                        if (slot) begin
                            tx_en_out <= 1'b1;
                            tx_data_out <= ~crc[7:0];
                            crc <= {8'hFF, crc[31:8]};
                            byte_cnt <= next_cnt;
                            fcs_idx <= 2'(fcs_idx + 2'h1);
                            if (fcs_idx == `MTC_FCS_LAST) begin
                                commit_ptr <= rd_ptr;
                                retire_pulse <= 1'b1;
                                attempts <= 4'h0;
                                gap_cnt <= 4'h0;
                                state <= MTC_ST_GAP;
                            end
                        end
                    end
                    MTC_ST_GAP: begin
                        if (slot) begin
                            tx_en_out <= 1'b0;
                            gap_cnt <= 4'(gap_cnt + 4'h1);
                            if (gap_cnt == `MTC_GAP_SLOTS_LAST) begin
                                state <= MTC_ST_IDLE;
                            end
                        end
                    end
                    MTC_ST_DRAIN: begin
                        // Drop the rest of the packet as it arrives
                        if (slot) begin
                            tx_en_out <= 1'b0;
                            if (avail) begin
                                rd_ptr <= 9'(rd_ptr + 9'h001);
                                if (rd_data[8]) begin
                                    commit_ptr <= 9'(rd_ptr + 9'h001);
                                    retire_pulse <= 1'b1;
                                    attempts <= 4'h0;
                                    gap_cnt <= 4'h0;
                                    state <= MTC_ST_GAP;
                                end
                            end
                        end
                    end
                    MTC_ST_HALT: begin
                        // Hold the FIFO flushed until software restarts
                        tx_en_out <= 1'b0;
                        rd_ptr <= wr_ptr;
                        commit_ptr <= wr_ptr;
                        attempts <= 4'h0;
                        if (cfg_bus.restart) begin
                            state <= MTC_ST_IDLE;
                        end
                    end
                    default: begin
                        state <= MTC_ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // mtc_top
